// [shared/pwr_clk_pkg.sv]
// Purpose: constants and types for the power mode clock controller
// Assumes: classic wishbone register access, one 50 MHz clock
// Notes:   register offsets are byte addresses of aligned 32-bit words
//
// Overview of operation
// - high speed: base clock is main undivided
// - medium speed: main divided by 2/4/8/16
// - low speed: base clock from secondary oscillator
// - low power: main stopped, secondary clocks cpu
// - wait: cpu clock halted, oscillators run
// - stop: all oscillators and clocks halted
// - selectable drive strength for both oscillators
// - enabled interrupt or reset ends wait/stop
// - waking interrupt stays pending for cpu
// - wait exit restores previous base clock
// - stop from main sets divide-by-eight bit
// - stop from low speed keeps clock bits
// - key and ext irqs wake any; serial one wait only
// - serial zero wakes deep only external clock
// - timers wake deep only counting external events
// - converter wakes only wait, one-shot modes
// - all-clock-stop enters stop, wake clears it
package pwr_clk_pkg;

  // register byte offsets
  localparam logic [7:0] ctrl0_addr  = 8'h00;
  localparam logic [7:0] ctrl1_addr  = 8'h04;
  localparam logic [7:0] status_addr = 8'h08;
  localparam logic [7:0] wakecfg_addr = 8'h0c;

  // ctrl0 field positions
  localparam int wait_peripheral_clock_stop_bit = 2;
  localparam int divide_by_eight_select_bit     = 6;
  localparam int system_clock_source_select_bit = 7;
  // ctrl1 field positions
  localparam int all_clock_stop_bit    = 0;
  localparam int main_osc_stop_bit     = 5;
  localparam int main_div_select_lo_bit = 6;
  localparam int main_div_select_hi_bit = 7;
  localparam int main_drive_high_bit   = 1;
  localparam int sec_drive_high_bit    = 3;

  // reset values: main divided by eight, high drive on both
  localparam logic [7:0] ctrl0_rst = 8'h40;
  localparam logic [7:0] ctrl1_rst = 8'h0a;
  localparam logic [7:0] wakecfg_rst = 8'h00;

  // wake source count and positions
  localparam int n_wake      = 8;
  localparam int wk_key      = 0;
  localparam int wk_ext0     = 1;
  localparam int wk_ext1     = 2;
  localparam int wk_ser0     = 3;
  localparam int wk_ser1     = 4;
  localparam int wk_timer    = 5;
  localparam int wk_adc      = 6;
  localparam int wk_spare    = 7;

  // divider
  localparam logic [3:0] div_max = 4'hf;

  typedef enum logic [1:0] {st_run, st_wait, st_stop} pwr_state_t;

endpackage

// [rtl/power_mode_clock_controller.sv]
// Purpose: base clock select, wait/stop sequencing and wake logic
// Assumes: clk_i is the main oscillator domain; enables model clocks
// Notes:   clocks leave as one-cycle enables, never gated clocks
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module power_mode_clock_controller
  import pwr_clk_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // secondary oscillator tick, asynchronous
  input  wire logic               sec_osc_tick_i,
  // cpu core
  input  wire logic               wait_req_i,
  output logic                    cpu_clk_en_o,
  output logic                    periph_clk_en_o,
  output logic                    sub_periph_clk_en_o,
  // oscillator control
  output logic                    main_osc_en_o,
  output logic                    sec_osc_en_o,
  output logic                    main_drive_high_o,
  output logic                    sec_drive_high_o,
  // interrupt sources and wake qualifiers
  input  wire logic [n_wake-1:0]  irq_i,
  input  wire logic               ser0_ext_clk_i,
  input  wire logic               timer_ext_event_i,
  input  wire logic               adc_one_shot_i,
  // state
  output pwr_clk_pkg::pwr_state_t state_o,
  output logic [n_wake-1:0]       irq_pending_o
);
  import pwr_clk_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  ctrl0;
  logic [7:0]  ctrl1;
  logic [7:0]  wakecfg;
  logic [1:0]  sec_sync;
  logic        sec_prev;
  logic [3:0]  div_cnt;
  logic        base_en;
  logic        sec_edge;
  logic        wake;
  logic        deep;
  logic [n_wake-1:0] wake_ok;
  pwr_state_t  state;
  pwr_state_t  next_state;

  logic wr;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////
  // secondary oscillator tick crosses in through two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_sync <= 2'h0;
      sec_prev <= 1'b0;
    end else begin
      sec_sync <= {sec_sync[0], sec_osc_tick_i};
      sec_prev <= sec_sync[1];
    end
  end
  assign sec_edge = sec_sync[1] & ~sec_prev;

  // main divider, free running while main oscillator enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 4'h0;
    end else if (main_osc_en_o) begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // base clock enable selection
  always_comb begin
    base_en = 1'b0;
    if (ctrl0[system_clock_source_select_bit]) begin
      base_en = sec_edge;
    end else if (ctrl0[divide_by_eight_select_bit]) begin
      base_en = main_osc_en_o && (div_cnt[2:0] == 3'h7);
    end else begin
      case ({ctrl1[main_div_select_hi_bit],
             ctrl1[main_div_select_lo_bit]})
        2'b00:   base_en = main_osc_en_o;
        2'b01:   base_en = main_osc_en_o && div_cnt[0];
        2'b10:   base_en = main_osc_en_o && (div_cnt[1:0] == 2'h3);
        default: base_en = main_osc_en_o && (div_cnt == div_max);
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-source wake qualification
  assign deep = (state == st_stop) ||
                ctrl0[wait_peripheral_clock_stop_bit];
  always_comb begin
    wake_ok = '0;
    wake_ok[wk_key]   = 1'b1;
    wake_ok[wk_ext0]  = 1'b1;
    wake_ok[wk_ext1]  = 1'b1;
    wake_ok[wk_ser1]  = ~deep;
    wake_ok[wk_ser0]  = ~deep | ser0_ext_clk_i;
    wake_ok[wk_timer] = ~deep | timer_ext_event_i;
    wake_ok[wk_adc]   = ~deep & adc_one_shot_i;
    wake_ok[wk_spare] = ~deep;
  end
  // enabled and allowed request ends the low power state
  assign wake = |(irq_i & wakecfg & wake_ok);

  ////////////////////////////////////////////////////////////////////////
  // power state
  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (ctrl1[all_clock_stop_bit]) begin
          next_state = st_stop;
        end else if (wait_req_i && base_en) begin
          next_state = st_wait;
        end
      end
      st_wait: if (wake) next_state = st_run;
      st_stop: if (wake) next_state = st_run;
      default: next_state = st_run;
    endcase
  end

  // hardware reset also leaves wait and stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= st_run;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register 0: stop entry forces divide by eight from main
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0 <= ctrl0_rst;
    end else if (state == st_run && next_state == st_stop) begin
      if (!ctrl0[system_clock_source_select_bit]) begin
        ctrl0[divide_by_eight_select_bit] <= 1'b1;
      end
    end else if (wr && wb_adr_i == ctrl0_addr) begin
      ctrl0 <= wb_dat_i[7:0];
    end
  end

  // control register 1: wake clears all-clock-stop, bits kept otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1 <= ctrl1_rst;
    end else if (state == st_stop && wake) begin
      ctrl1[all_clock_stop_bit] <= 1'b0;
    end else if (wr && wb_adr_i == ctrl1_addr) begin
      ctrl1 <= wb_dat_i[7:0];
    end
  end

  // wake source enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wakecfg <= wakecfg_rst;
    end else if (wr && wb_adr_i == wakecfg_addr) begin
      wakecfg <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock enables and oscillator controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o        <= 1'b0;
      periph_clk_en_o     <= 1'b0;
      sub_periph_clk_en_o <= 1'b0;
      main_osc_en_o       <= 1'b1;
      sec_osc_en_o        <= 1'b1;
      main_drive_high_o   <= 1'b1;
      sec_drive_high_o    <= 1'b1;
    end else begin
      // cpu halted in wait and stop, resumes same selection except divide by eight after stop from main
      cpu_clk_en_o <= (next_state == st_run) && base_en;
      // main stop bit only honoured while on secondary clock
      main_osc_en_o <= (next_state != st_stop) &&
                       !(ctrl1[main_osc_stop_bit] &&
                         ctrl0[system_clock_source_select_bit]);
      sec_osc_en_o <= (next_state != st_stop);
      periph_clk_en_o <= main_osc_en_o && (next_state != st_stop) &&
        !(next_state == st_wait &&
          ctrl0[wait_peripheral_clock_stop_bit]);
      sub_periph_clk_en_o <= (next_state != st_stop) && sec_edge;
      main_drive_high_o <= ctrl1[main_drive_high_bit];
      sec_drive_high_o  <= ctrl1[sec_drive_high_bit];
    end
  end

  // waking requests are left pending for the cpu to service
  assign irq_pending_o = irq_i & wakecfg;
  assign state_o = state;

  ////////////////////////////////////////////////////////////////////////
  // wishbone answer: one cycle after request, zero for unmapped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        ctrl0_addr:   wb_dat_o <= {24'h0, ctrl0};
        ctrl1_addr:   wb_dat_o <= {24'h0, ctrl1};
        status_addr:  wb_dat_o <= {22'h0, main_osc_en_o, sec_osc_en_o,
                                   irq_pending_o[7:2], state};
        wakecfg_addr: wb_dat_o <= {24'h0, wakecfg};
        default:      wb_dat_o <= 32'h0;
      endcase
    end
  end

endmodule

// [sim/pwr_partner.sv]
// Purpose: cpu core, irq sources, secondary crystal
// Assumes: a source holds its request until serviced
// Notes:   crystal halts while its enable is low
`timescale 1ns/1ps
module pwr_partner
  import pwr_clk_pkg::*;
(
  // clock, reset, bench commands
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [n_wake-1:0]  raise_i,
  input  wire logic [n_wake-1:0]  clr_i,
  input  wire logic               go_wait_i,
  // controller side
  input  wire logic               sec_osc_en_i,
  input  pwr_clk_pkg::pwr_state_t state_i,
  output logic [n_wake-1:0]       irq_o,
  output logic                    wait_req_o,
  output logic                    sec_osc_tick_o
);
  logic [2:0] osc;
  // request stays up until the cpu services it
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= '0;
    else irq_o <= (irq_o | raise_i) & ~clr_i;
  end
  // wait strobe held until the controller reports wait
  always_ff @(posedge clk_i) begin
    if (rst_i || state_i == st_wait) wait_req_o <= 1'h0;
    else if (go_wait_i) wait_req_o <= 1'h1;
  end
  // no ticks while halted, so a stuck enable shows up
  always_ff @(posedge clk_i) begin
    if (rst_i) osc <= 3'h0;
    else if (sec_osc_en_i) osc <= osc + 3'h1;
  end
  assign sec_osc_tick_o = osc[2];
endmodule

// [sim/power_mode_clock_controller_chk.sv]
// Purpose: port checks of the power mode clock controller
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every controller instance
`timescale 1ns/1ps
module power_mode_clock_controller_chk
  import pwr_clk_pkg::*;
(
  // clock, reset, bus handshake
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  // enables and state
  input wire logic                cpu_clk_en_o,
  input wire logic                periph_clk_en_o,
  input wire logic                sub_periph_clk_en_o,
  input wire logic                main_osc_en_o,
  input wire logic                sec_osc_en_o,
  input pwr_clk_pkg::pwr_state_t  state_o,
  input wire logic [n_wake-1:0]   irq_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // same-cycle and multi-step behaviours
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_wake; state_o == st_stop ##1 state_o == st_run; endsequence
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  property p_stop_osc;
    state_o == st_stop |-> !main_osc_en_o && !sec_osc_en_o;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("osc on");
  property p_stop_clk; state_o == st_stop [*2] |->
    !(cpu_clk_en_o || periph_clk_en_o || sub_periph_clk_en_o);
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clk on");
  property p_wait_cpu; state_o == st_wait [*2] |-> !cpu_clk_en_o; endproperty
  a_wait_cpu: assert property (p_wait_cpu) else $error("cpu on");
  property p_wait_osc; state_o == st_wait |-> sec_osc_en_o; endproperty
  a_wait_osc: assert property (p_wait_osc) else $error("osc off");
  property p_wake; state_o != st_run && (irq_pending_o[wk_key] ||
    irq_pending_o[wk_ext0] || irq_pending_o[wk_ext1]) |=> state_o == st_run;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_wake_osc; s_wake |-> ##[0:1] sec_osc_en_o; endproperty
  a_wake_osc: assert property (p_wake_osc) else $error("no osc");
  property p_ser1_hold;
    state_o == st_stop && irq_pending_o == 8'h10 |=> state_o == st_stop;
  endproperty
  a_ser1_hold: assert property (p_ser1_hold) else $error("woke");
endmodule
bind power_mode_clock_controller power_mode_clock_controller_chk u_chk (.*);

// [sim/power_mode_clock_controller_tb.sv]
// Purpose: bus-driven checks of clock modes, wait, stop
// Assumes: wake mask written before each wait or stop
// Notes:   enable pulses counted over 64-cycle windows
`timescale 1ns/1ps
module power_mode_clock_controller_tb;
  import pwr_clk_pkg::*;
  logic              clk_i = 1'h0, rst_i = 1'h1, wb_we_i = 1'h0;
  logic              wb_cyc_i = 1'h0, wb_stb_i = 1'h0, go_wait = 1'h0;
  logic              ser0_ext_clk_i = 1'h0, timer_ext_event_i = 1'h0;
  logic              adc_one_shot_i = 1'h0;
  logic              wb_ack_o, cpu_clk_en_o, periph_clk_en_o, wait_req_i;
  logic              sub_periph_clk_en_o, main_osc_en_o, sec_osc_en_o;
  logic              main_drive_high_o, sec_drive_high_o, sec_osc_tick_i;
  logic [7:0]        wb_adr_i = 8'h0;
  logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, q;
  logic [n_wake-1:0] raise = 8'h0, clr = 8'h0, irq_i, irq_pending_o;
  pwr_state_t        state_o;
  int                n_mismatch = 0, tests_run = 0, cycles = 0;
  logic [7:0]        ra [4] = '{ctrl0_addr, ctrl1_addr, wakecfg_addr, 8'h10};
  logic [7:0]        rv [4] = '{ctrl0_rst, ctrl1_rst, wakecfg_rst, 8'h00};
  logic [7:0]        d0 [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  logic [7:0]        d1 [5] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h00};
  int                ex [5] = '{64, 32, 16, 4, 8};
  power_mode_clock_controller u_dut (.*, .wb_sel_i(4'hf));
  pwr_partner u_partner (.clk_i, .rst_i, .raise_i(raise), .clr_i(clr),
    .go_wait_i(go_wait), .sec_osc_en_i(sec_osc_en_o), .state_i(state_o),
    .irq_o(irq_i), .wait_req_o(wait_req_i), .sec_osc_tick_o(sec_osc_tick_i));
  ////////////////////////////////////////
  // clock and hang guard
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // settle, then count base enables
  task automatic cnt(input int e);
    int n;
    n = 0;
    repeat (32) @(posedge clk_i);
    repeat (64) begin
      @(posedge clk_i);
      if (cpu_clk_en_o === 1'h1) n++;
    end
    chk(32'(n), 32'(e));
  endtask
  task automatic ev(input logic [7:0] r, input logic [7:0] c);
    raise <= r;
    clr <= c;
    @(posedge clk_i);
    raise <= 8'h0;
    clr <= 8'h0;
  endtask
  task automatic wst(input pwr_state_t s);
    while (state_o !== s) @(posedge clk_i);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    // reset values; unmapped word reads zero
    for (int i = 0; i < 4; i++) begin
      wb(1'h0, ra[i], 32'h0);
      chk(q, {24'h0, rv[i]});
    end
    // status after reset: both oscillators on, running, nothing pending on sources 2 to 7
    wb(1'h0, status_addr, 32'h0);
    chk(q, 32'h300);
    chk(32'({main_drive_high_o, sec_drive_high_o}), 32'h3);
    for (int i = 0; i < 5; i++) begin
      wb(1'h1, ctrl0_addr, 32'(d0[i]));
      wb(1'h1, ctrl1_addr, 32'(d1[i]));
      cnt(ex[i]);
    end
    chk(32'({main_drive_high_o, sec_drive_high_o}), 32'h0);
    // low speed, then main crystal off
    wb(1'h1, ctrl0_addr, 32'h80);
    cnt(8);
    wb(1'h1, ctrl1_addr, 32'h20);
    cnt(8);
    chk(32'(main_osc_en_o), 32'h0);
    // wait with peripheral clock gated, sub-peripheral clock still running
    wb(1'h1, ctrl1_addr, 32'h40);
    wb(1'h1, ctrl0_addr, 32'h04);
    wb(1'h1, wakecfg_addr, 32'h01);
    go_wait <= 1'h1;
    @(posedge clk_i);
    go_wait <= 1'h0;
    wst(st_wait);
    repeat (4) @(posedge clk_i);
    chk(32'(periph_clk_en_o), 32'h0);
    ev(8'h01, 8'h00);
    wst(st_run);
    chk(32'(irq_pending_o), 32'h01);
    cnt(32);
    ev(8'h00, 8'hff);
    // converter wakes wait only while in a one-shot mode
    wb(1'h1, ctrl0_addr, 32'h00);
    wb(1'h1, wakecfg_addr, 32'h40);
    go_wait <= 1'h1;
    @(posedge clk_i);
    go_wait <= 1'h0;
    wst(st_wait);
    ev(8'h40, 8'h00);
    repeat (8) @(posedge clk_i);
    chk(32'(state_o), 32'(st_wait));
    adc_one_shot_i <= 1'h1;
    wst(st_run);
    chk(32'(irq_pending_o), 32'h40);
    ev(8'h00, 8'hff);
    adc_one_shot_i <= 1'h0;
    // stop from main: serial one, serial zero on own clock stay asleep
    wb(1'h1, ctrl0_addr, 32'h00);
    wb(1'h1, wakecfg_addr, 32'h1a);
    wb(1'h1, ctrl1_addr, 32'h41);
    wst(st_stop);
    ev(8'h10, 8'h00);
    repeat (8) @(posedge clk_i);
    chk(32'(state_o), 32'(st_stop));
    ev(8'h08, 8'h00);
    repeat (8) @(posedge clk_i);
    chk(32'(state_o), 32'(st_stop));
    ev(8'h02, 8'h00);
    wst(st_run);
    wb(1'h0, ctrl0_addr, 32'h0);
    chk(q, 32'h40);
    wb(1'h0, ctrl1_addr, 32'h0);
    chk(q, 32'h40);
    ev(8'h00, 8'hff);
    // stop from low speed, timer on external events wakes
    wb(1'h1, ctrl0_addr, 32'h80);
    wb(1'h1, wakecfg_addr, 32'h20);
    timer_ext_event_i <= 1'h1;
    wb(1'h1, ctrl1_addr, 32'h01);
    wst(st_stop);
    ev(8'h20, 8'h00);
    wst(st_run);
    wb(1'h0, ctrl0_addr, 32'h0);
    chk(q, 32'h80);
    end_of_test();
  end
endmodule
